/* core/rsi_status.sv */
`timescale 1ns/10ps
`include "rsi_defines.svh"

// Operation
// - Function-on shows whenever reclosing is enabled.
// - Function-off shows only when on/off input is used and inactive.
// - Breaker opened and timing to close: in-progress and dead-time both show.
// - Each request-active shows while a shot started by that request runs.
// - Running shows while the sequencer is in running mode; the code also requires the block not to be locked.
// - One shot-running flag per shot 1..5, set while that shot executes.
// - Sequence-finished shows after last-shot close until final trip or reclaim end.
// - Final-trip shows once the final trip command has been issued.
// - Arcing-time shows while the arcing timer counts.
// - Reclaim-time shows while the reclaim timer counts.
// - Ready shows whenever a sequence could start on a fault.
// - Fault during post-success lockout time: flag it, start nothing, go locked.
// - Inhibit shows while the sequencer is in inhibit mode; the code also requires the block not to be locked.
// - Locked shows while the sequencer is in locked mode.
// - Request one has highest priority, five lowest; higher overrides lower.
// - Critical request moves the block to locked at once.
// - Once locked, stay locked until manual reset.
module rsi_status #(
    parameter int NUM_REQ = `RSI_NUM_REQ,
    parameter int NUM_SHOT = `RSI_NUM_SHOT
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic function_enable_in,
    input wire logic use_on_off_input_in,
    input wire logic on_off_pin_in,
    input wire rsi_pkg::rsi_mode_type seq_mode_in,
    input wire rsi_pkg::rsi_phase_type seq_phase_in,
    input wire logic breaker_open_in,
    input wire logic shot_start_in,
    input wire logic [2:0] shot_number_in,
    input wire logic priority_request_one_in,
    input wire logic priority_request_two_in,
    input wire logic priority_request_three_in,
    input wire logic priority_request_four_in,
    input wire logic priority_request_five_in,
    input wire logic last_shot_closed_in,
    input wire logic final_trip_cmd_in,
    input wire logic sequence_end_in,
    input wire logic fault_detected_in,
    input wire logic critical_request_in,
    input wire logic manual_reset_in,
    output logic reclose_function_on_out,
    output logic reclose_function_off_out,
    output logic reclose_in_progress_out,
    output logic dead_time_active_out,
    output logic [NUM_REQ-1:0] request_active_out,
    output logic running_out,
    output logic [NUM_SHOT-1:0] shot_running_out,
    output logic sequence_finished_out,
    output logic final_trip_issued_out,
    output logic arcing_time_active_out,
    output logic reclaim_time_active_out,
    output logic ready_out,
    output logic post_success_lockout_out,
    output logic operation_inhibited_out,
    output logic sequencer_locked_out
);
    import rsi_pkg::*;

    logic on_off_sync;
    logic [NUM_REQ-1:0] req_raw;
    logic [NUM_REQ-1:0] req_win;
    logic enabled;
    logic locked_r;
    logic lockout_hit;
    logic in_sequence;
    logic [NUM_REQ-1:0] req_latched_r;
    logic [NUM_SHOT-1:0] shot_latched_r;
    logic finished_r;
    logic final_trip_r;

    // Picks the lowest-numbered active bit, which is the highest priority.
    function automatic logic [NUM_REQ-1:0] pick_first(input logic [NUM_REQ-1:0] req);
        logic [NUM_REQ-1:0] res;
        res = '0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (req[i]) begin
                res = '0;
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

    // Converts a shot number 1..N into a one-hot flag; out of range gives none.
    function automatic logic [NUM_SHOT-1:0] shot_onehot(input logic [2:0] num);
        logic [NUM_SHOT-1:0] res;
        res = '0;
        for (int i = 0; i < NUM_SHOT; i++) begin
            if (num == 3'(i + 1)) begin
                res[i] = 1'b1;
            end
        end
        return res;
    endfunction

    // The on/off input is a device pin and so crosses into this clock.
    rsi_sync #(
        .WIDTH(1)
    ) u_on_off_sync (
        .clk_sys_in(clk_sys_in),
        .rstn_in(rstn_in),
        .async_in(on_off_pin_in),
        .sync_out(on_off_sync)
    );

    // Gather the request inputs and keep only the highest-priority one.
    assign req_raw = {priority_request_five_in, priority_request_four_in, priority_request_three_in,
                      priority_request_two_in, priority_request_one_in};
    assign req_win = pick_first(req_raw);

    // Enabled when the mode is on and, if the input is used, the input is active.
    assign enabled = function_enable_in && (!use_on_off_input_in || on_off_sync);

    // A fault while the lockout delay runs after a good sequence.
    assign lockout_hit = (seq_phase_in == RSI_PHASE_LOCKOUT) && fault_detected_in;

    // A sequence is live while the sequencer runs and the block is not locked.
    assign in_sequence = (seq_mode_in == RSI_MODE_RUNNING) && !locked_r;

    // Locking: critical request or post-success fault lock; only manual reset frees it.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            locked_r <= 1'b0;
        end else if (critical_request_in || lockout_hit) begin
            locked_r <= 1'b1;
        end else if (manual_reset_in) begin
            locked_r <= 1'b0;
        end
    end

    // Latch which request started the shot and which shot runs; cleared when the sequence ends.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            req_latched_r <= `RSI_ONEHOT_RST;
            shot_latched_r <= `RSI_ONEHOT_RST;
        end else if (!in_sequence || sequence_end_in || critical_request_in || lockout_hit) begin
            req_latched_r <= `RSI_ONEHOT_RST;
            shot_latched_r <= `RSI_ONEHOT_RST;
        end else if (shot_start_in && (req_win != '0)) begin
            req_latched_r <= req_win;
            shot_latched_r <= shot_onehot(shot_number_in);
        end
    end

    // Sequence-finished holds from last-shot close until final trip or reclaim end.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            finished_r <= 1'b0;
        end else if (last_shot_closed_in && in_sequence) begin
            finished_r <= 1'b1;
        end else if (final_trip_cmd_in || sequence_end_in || !in_sequence) begin
            finished_r <= 1'b0;
        end
    end

    // Final trip stays shown until manual reset clears it; a new trip wins over the reset.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            final_trip_r <= 1'b0;
        end else if (final_trip_cmd_in) begin
            final_trip_r <= 1'b1;
        end else if (manual_reset_in) begin
            final_trip_r <= 1'b0;
        end
    end

    // Enable indications.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            reclose_function_on_out <= 1'b0;
            reclose_function_off_out <= 1'b0;
        end else begin
            reclose_function_on_out <= enabled;
            reclose_function_off_out <= use_on_off_input_in && !on_off_sync;
        end
    end

    // Timing phase indications; dead time also means a reclose is in progress.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            reclose_in_progress_out <= 1'b0;
            dead_time_active_out <= 1'b0;
            arcing_time_active_out <= 1'b0;
            reclaim_time_active_out <= 1'b0;
        end else begin
            reclose_in_progress_out <= in_sequence && breaker_open_in
                                       && (seq_phase_in == RSI_PHASE_DEAD);
            dead_time_active_out <= in_sequence && breaker_open_in
                                    && (seq_phase_in == RSI_PHASE_DEAD);
            arcing_time_active_out <= seq_phase_in == RSI_PHASE_ARCING;
            reclaim_time_active_out <= seq_phase_in == RSI_PHASE_RECLAIM;
        end
    end

    // Shot and request indications; at most one of each by construction.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            request_active_out <= `RSI_ONEHOT_RST;
            shot_running_out <= `RSI_ONEHOT_RST;
            sequence_finished_out <= 1'b0;
            final_trip_issued_out <= 1'b0;
        end else begin
            request_active_out <= req_latched_r;
            shot_running_out <= shot_latched_r;
            sequence_finished_out <= finished_r;
            final_trip_issued_out <= final_trip_r;
        end
    end

    // Mode indications; the block's own lock overrides the sequencer's reported mode.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            running_out <= 1'b0;
            ready_out <= 1'b0;
            operation_inhibited_out <= 1'b0;
            sequencer_locked_out <= 1'b0;
            post_success_lockout_out <= 1'b0;
        end else begin
            running_out <= in_sequence;
            ready_out <= enabled && !locked_r && (seq_mode_in == RSI_MODE_READY)
                         && !critical_request_in;
            operation_inhibited_out <= (seq_mode_in == RSI_MODE_INHIBIT) && !locked_r;
            sequencer_locked_out <= locked_r || (seq_mode_in == RSI_MODE_LOCKED);
            if (lockout_hit) begin
                post_success_lockout_out <= 1'b1;
            end else if (manual_reset_in) begin
                post_success_lockout_out <= 1'b0;
            end
        end
    end

endmodule

/* core/rsi_defines.svh */
`ifndef RSI_DEFINES_SVH
`define RSI_DEFINES_SVH

// Number of request inputs and shots.
`define RSI_NUM_REQ 5
`define RSI_NUM_SHOT 5
// Reset value of the one-hot request and shot indications.
`define RSI_ONEHOT_RST 5'h00
// Reset value of the last latched request index (none).
`define RSI_REQ_NONE 3'h0

`endif

/* core/rsi_pkg.sv */
package rsi_pkg;

    // Operating modes of the reclosing sequencer as seen by the indication stage.
    typedef enum logic [2:0] {
        RSI_MODE_INHIBIT,
        RSI_MODE_READY,
        RSI_MODE_RUNNING,
        RSI_MODE_LOCKED,
        RSI_MODE_NOT_RUNNING
    } rsi_mode_type;

    // Timing phase that the sequencer currently counts.
    typedef enum logic [2:0] {
        RSI_PHASE_IDLE,
        RSI_PHASE_START,
        RSI_PHASE_DEAD,
        RSI_PHASE_ARCING,
        RSI_PHASE_RECLAIM,
        RSI_PHASE_LOCKOUT
    } rsi_phase_type;

endpackage

/* core/rsi_sync.sv */
`timescale 1ns/10ps

// Three-stage synchroniser; the output moves only when stages two and three agree.
module rsi_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] mid_r;
    logic [WIDTH-1:0] last_r;

    // Shift the raw level through three flops.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            meta_r <= '0;
            mid_r <= '0;
            last_r <= '0;
        end else begin
            meta_r <= async_in;
            mid_r <= meta_r;
            last_r <= mid_r;
        end
    end

    // Accept a new level per bit only when the second and third stages agree.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in) begin
            sync_out <= '0;
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (mid_r[i] == last_r[i]) begin
                    sync_out[i] <= last_r[i];
                end
            end
        end
    end

endmodule

/* testbench/rsi_status_assertions.sv */
`timescale 1ns/10ps
// Compares the indication outputs with the sequencer inputs sampled one or two cycles before.
module rsi_status_checker
    import rsi_pkg::*;
#(
    parameter int NUM_REQ = 5,
    parameter int NUM_SHOT = 5
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic function_enable_in,
    input wire logic use_on_off_input_in,
    input wire rsi_pkg::rsi_mode_type seq_mode_in,
    input wire rsi_pkg::rsi_phase_type seq_phase_in,
    input wire logic critical_request_in,
    input wire logic reclose_function_on_out,
    input wire logic reclose_function_off_out,
    input wire logic reclose_in_progress_out,
    input wire logic dead_time_active_out,
    input wire logic [NUM_REQ-1:0] request_active_out,
    input wire logic running_out,
    input wire logic [NUM_SHOT-1:0] shot_running_out,
    input wire logic arcing_time_active_out,
    input wire logic reclaim_time_active_out,
    input wire logic ready_out,
    input wire logic operation_inhibited_out,
    input wire logic sequencer_locked_out
);
    // All checks use the system clock and pause while reset is low.
    default clocking @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);
    // With the on/off input in use, function-on also needs the pin, which shows as function-off low.
    func_on_a: assert property (
        $past(rstn_in) |-> reclose_function_on_out == ($past(function_enable_in)
            && (!$past(use_on_off_input_in) || !reclose_function_off_out))) else $error("function on wrong");
    on_off_excl_a: assert property (
        !(reclose_function_on_out && reclose_function_off_out)) else $error("function on and off together");
    dead_pair_a: assert property (
        dead_time_active_out == reclose_in_progress_out) else $error("dead time and in progress differ");
    arcing_a: assert property (
        $past(rstn_in) |-> arcing_time_active_out == ($past(seq_phase_in) == RSI_PHASE_ARCING)) else $error("arcing wrong");
    reclaim_a: assert property (
        $past(rstn_in) |-> reclaim_time_active_out == ($past(seq_phase_in) == RSI_PHASE_RECLAIM)) else $error("reclaim wrong");
    inhibit_a: assert property (
        $past(rstn_in) |-> operation_inhibited_out == (($past(seq_mode_in) == RSI_MODE_INHIBIT)
            && !sequencer_locked_out)) else $error("inhibit wrong");
    running_a: assert property (
        running_out |-> $past(seq_mode_in) == RSI_MODE_RUNNING) else $error("running outside running mode");
    ready_a: assert property (
        ready_out |-> $past(function_enable_in) && $past(seq_mode_in) == RSI_MODE_READY) else $error("ready wrong");
    one_hot_a: assert property (
        $onehot0(request_active_out) && $onehot0(shot_running_out)) else $error("two flags active");
    crit_lock_a: assert property (
        $past(rstn_in) && critical_request_in |-> ##2 sequencer_locked_out && !running_out) else $error("not locked");
endmodule

bind rsi_status rsi_status_checker #(
    .NUM_REQ(NUM_REQ),
    .NUM_SHOT(NUM_SHOT)
) i_chk (
    .clk_sys_in(clk_sys_in),
    .rstn_in(rstn_in),
    .function_enable_in(function_enable_in),
    .use_on_off_input_in(use_on_off_input_in),
    .seq_mode_in(seq_mode_in),
    .seq_phase_in(seq_phase_in),
    .critical_request_in(critical_request_in),
    .reclose_function_on_out(reclose_function_on_out),
    .reclose_function_off_out(reclose_function_off_out),
    .reclose_in_progress_out(reclose_in_progress_out),
    .dead_time_active_out(dead_time_active_out),
    .request_active_out(request_active_out),
    .running_out(running_out),
    .shot_running_out(shot_running_out),
    .arcing_time_active_out(arcing_time_active_out),
    .reclaim_time_active_out(reclaim_time_active_out),
    .ready_out(ready_out),
    .operation_inhibited_out(operation_inhibited_out),
    .sequencer_locked_out(sequencer_locked_out)
);

/* testbench/rsi_object_ctrl_model.sv */
`timescale 1ns/10ps
// Object control stand-in: the only party that moves the breaker, one cycle after a command.
module rsi_object_ctrl_model (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic open_cmd_in,
    input wire logic close_cmd_in,
    output logic breaker_open_out
);
    // A close command wins over an open command so the breaker never sits in between.
    always_ff @(posedge clk_sys_in) begin
        if (!rstn_in || close_cmd_in) begin
            breaker_open_out <= 1'h0;
        end else if (open_cmd_in) begin
            breaker_open_out <= 1'h1;
        end
    end
endmodule

/* testbench/tb_reclosing_status_indications.sv */
`timescale 1ns/10ps
// Walks the indication stage through modes, phases, shots and lock cases.
module tb_reclosing_status_indications;
    import rsi_pkg::*;
    logic clk_sys_in = 1'h0;
    logic rstn_in, en, use_pin, pin, brk, opn, cls, start, last, ftrip, send, fault, crit, mres;
    logic [2:0] shot_num;
    logic [4:0] req, req_act, shot_run;
    rsi_mode_type mode;
    rsi_phase_type phase;
    logic on_o, off_o, prog_o, dead_o, run_o, fin_o, ft_o, arc_o, recl_o, rdy_o, psl_o, inh_o, lck_o;
    int error_cnt = 0;
    int checks = 0;
    rsi_object_ctrl_model i_obj (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .open_cmd_in(opn), .close_cmd_in(cls),
        .breaker_open_out(brk));
    rsi_status i_dut (.clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .function_enable_in(en), .use_on_off_input_in(use_pin),
        .on_off_pin_in(pin), .seq_mode_in(mode), .seq_phase_in(phase), .breaker_open_in(brk), .shot_start_in(start),
        .shot_number_in(shot_num), .priority_request_one_in(req[0]), .priority_request_two_in(req[1]),
        .priority_request_three_in(req[2]), .priority_request_four_in(req[3]), .priority_request_five_in(req[4]),
        .last_shot_closed_in(last), .final_trip_cmd_in(ftrip), .sequence_end_in(send), .fault_detected_in(fault),
        .critical_request_in(crit), .manual_reset_in(mres), .reclose_function_on_out(on_o),
        .reclose_function_off_out(off_o), .reclose_in_progress_out(prog_o), .dead_time_active_out(dead_o),
        .request_active_out(req_act), .running_out(run_o), .shot_running_out(shot_run), .sequence_finished_out(fin_o),
        .final_trip_issued_out(ft_o), .arcing_time_active_out(arc_o), .reclaim_time_active_out(recl_o),
        .ready_out(rdy_o), .post_success_lockout_out(psl_o), .operation_inhibited_out(inh_o),
        .sequencer_locked_out(lck_o));
    task automatic chk(input string nm, input logic [4:0] exp, input logic [4:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic tally_and_finish();
        $display("checks %0d error_cnt %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Free-running system clock.
    initial begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    // Cuts a hung run short.
    initial begin
        #200us;
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence; inputs move by non-blocking assignment on the rising edge.
    initial begin
        {rstn_in, en, use_pin, pin, opn, cls, start, last, ftrip, send, fault, crit, mres} = 13'h0000;
        shot_num = 3'h0;
        req = 5'h00;
        mode = RSI_MODE_INHIBIT;
        phase = RSI_PHASE_IDLE;
        repeat (5) @(posedge clk_sys_in);
        rstn_in <= 1'h1;
        en <= 1'h1;
        use_pin <= 1'h1;
        wt(8);
        // The on/off input is in use and inactive, so the function counts as not enabled.
        chk("function on", 5'h00, on_o);
        chk("function off", 5'h01, off_o);
        @(posedge clk_sys_in);
        pin <= 1'h1;
        wt(8);
        chk("function off", 5'h00, off_o);
        chk("function on", 5'h01, on_o);
        // With the on/off input not in use the pin is ignored.
        @(posedge clk_sys_in);
        use_pin <= 1'h0;
        pin <= 1'h0;
        wt(8);
        chk("function on", 5'h01, on_o);
        chk("function off", 5'h00, off_o);
        for (int m = 0; m < 5; m++) begin
            @(posedge clk_sys_in);
            mode <= rsi_mode_type'(m);
            wt(3);
            chk("running", {4'h0, mode == RSI_MODE_RUNNING}, run_o);
            chk("ready", {4'h0, mode == RSI_MODE_READY}, rdy_o);
            chk("inhibit", {4'h0, mode == RSI_MODE_INHIBIT}, inh_o);
            chk("locked", {4'h0, mode == RSI_MODE_LOCKED}, lck_o);
        end
        @(posedge clk_sys_in);
        mode <= RSI_MODE_RUNNING;
        opn <= 1'h1;
        for (int p = 0; p < 6; p++) begin
            @(posedge clk_sys_in);
            opn <= 1'h0;
            phase <= rsi_phase_type'(p);
            wt(3);
            chk("in progress", {4'h0, phase == RSI_PHASE_DEAD}, prog_o);
            chk("dead time", {4'h0, phase == RSI_PHASE_DEAD}, dead_o);
            chk("arcing", {4'h0, phase == RSI_PHASE_ARCING}, arc_o);
            chk("reclaim", {4'h0, phase == RSI_PHASE_RECLAIM}, recl_o);
        end
        // Request k and every higher-numbered, lower-priority one are raised together; only k may win.
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_sys_in);
            req <= 5'h1F << k;
            shot_num <= 3'(k + 1);
            start <= 1'h1;
            @(posedge clk_sys_in);
            start <= 1'h0;
            wt(2);
            chk("request active", 5'h01 << k, req_act);
            chk("shot running", 5'h01 << k, shot_run);
            @(posedge clk_sys_in);
            send <= 1'h1;
            @(posedge clk_sys_in);
            send <= 1'h0;
            wt(2);
            chk("shot cleared", 5'h00, shot_run);
        end
        @(posedge clk_sys_in);
        last <= 1'h1;
        cls <= 1'h1;
        @(posedge clk_sys_in);
        last <= 1'h0;
        cls <= 1'h0;
        wt(2);
        chk("finished", 5'h01, fin_o);
        @(posedge clk_sys_in);
        ftrip <= 1'h1;
        @(posedge clk_sys_in);
        ftrip <= 1'h0;
        wt(2);
        chk("final trip", 5'h01, ft_o);
        chk("finished", 5'h00, fin_o);
        @(posedge clk_sys_in);
        fault <= 1'h1;
        wt(3);
        chk("post success lockout", 5'h01, psl_o);
        chk("locked", 5'h01, lck_o);
        chk("running", 5'h00, run_o);
        @(posedge clk_sys_in);
        fault <= 1'h0;
        phase <= RSI_PHASE_IDLE;
        crit <= 1'h1;
        mres <= 1'h1;
        wt(3);
        chk("locked", 5'h01, lck_o);
        @(posedge clk_sys_in);
        crit <= 1'h0;
        mres <= 1'h0;
        wt(6);
        chk("locked", 5'h01, lck_o);
        @(posedge clk_sys_in);
        mres <= 1'h1;
        wt(3);
        chk("locked", 5'h00, lck_o);
        chk("post success lockout", 5'h00, psl_o);
        // A critical request from the unlocked running state must lock at once.
        @(posedge clk_sys_in);
        mres <= 1'h0;
        crit <= 1'h1;
        @(posedge clk_sys_in);
        crit <= 1'h0;
        wt(2);
        chk("locked", 5'h01, lck_o);
        chk("running", 5'h00, run_o);
        tally_and_finish();
    end
endmodule
